// >>> hw/dpra_pkg.sv
package dpra_pkg;

  // Bank geometry
  localparam int DPRA_NREG = 13;
  localparam int DPRA_AW   = 16;
  localparam int DPRA_DW   = 32;
  localparam int DPRA_BW   = 8;

  // Register indices; byte address is four times the index
  localparam logic [11:0] DPRA_IDX_PRIO_EN  = 12'h0440;
  localparam logic [11:0] DPRA_IDX_BW_LOW   = 12'h0441;
  localparam logic [11:0] DPRA_IDX_BW_HIGH  = 12'h0442;
  localparam logic [11:0] DPRA_IDX_LF_SEL   = 12'h0443;
  localparam logic [11:0] DPRA_IDX_INT_LOW  = 12'h0444;
  localparam logic [11:0] DPRA_IDX_INT_MID  = 12'h0445;
  localparam logic [11:0] DPRA_IDX_INT_TOP  = 12'h0446;
  localparam logic [11:0] DPRA_IDX_NUM_LOW  = 12'h0447;
  localparam logic [11:0] DPRA_IDX_NUM_MID  = 12'h0448;
  localparam logic [11:0] DPRA_IDX_NUM_HIGH = 12'h0449;
  localparam logic [11:0] DPRA_IDX_MOD_LOW  = 12'h044A;
  localparam logic [11:0] DPRA_IDX_MOD_MID  = 12'h044B;
  localparam logic [11:0] DPRA_IDX_MOD_HIGH = 12'h044C;
  localparam logic [11:0] DPRA_IDX_STATUS   = 12'h0460;

  // Field positions
  localparam int DPRA_EN_BIT    = 0;
  localparam int DPRA_RANK_LSB  = 1;
  localparam int DPRA_LF_BIT    = 1;
  localparam int DPRA_INTTOP_B  = 0;
  localparam int DPRA_ST_FRACOK = 24;
  localparam int DPRA_ST_MODZ   = 25;

  // Reset values, entry n belongs to register base index plus n
  localparam logic [DPRA_NREG-1:0][7:0] DPRA_RST = {
    8'h00, 8'h00, 8'h05, 8'h00, 8'h00, 8'h04, 8'h00,
    8'h07, 8'hCB, 8'h00, 8'h01, 8'hF4, 8'h01};

  // Writable bits; reserved bits stay zero
  localparam logic [DPRA_NREG-1:0][7:0] DPRA_MASK = {
    8'h7F, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'h01,
    8'hFF, 8'hFF, 8'h02, 8'hFF, 8'hFF, 8'h07};

  // Phase margin choice of the base loop filter
  typedef enum logic {
    DPRA_MARGIN_NORMAL,
    DPRA_MARGIN_HIGH
  } dpra_margin_t;

  // Settings handed to the loop datapath
  typedef struct packed {
    logic         enable;
    logic [1:0]   rank;
    logic [15:0]  loop_bw;
    dpra_margin_t margin;
    logic [16:0]  int_m1;
    logic [22:0]  num;
    logic [22:0]  modulus;
  } dpra_cfg_t;

  // Effective division presented to the loop
  typedef struct packed {
    logic [17:0] int_div;
    logic        frac_ok;
    logic        mod_zero;
  } dpra_div_t;

  // Bus handshake states
  typedef enum logic [1:0] {
    DPRA_IDLE,
    DPRA_ANSWER
  } dpra_apb_st_t;

endpackage

// >>> hw/dpra_byte_reg.sv
module dpra_byte_reg
  import dpra_pkg::*;
#(
  parameter logic [7:0] RST_VAL = 8'h00,
  parameter logic [7:0] WR_MASK = 8'hFF
)(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       we,
  input  wire logic [7:0] wdata,
  output logic      [7:0] q
);

  // Byte store; reserved bits never take a one
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= RST_VAL & WR_MASK;
    else if (we)
      q <= wdata & WR_MASK;
  end

endmodule // dpra_byte_reg

// >>> hw/dpra_div_calc.sv
module dpra_div_calc
  import dpra_pkg::*;
(
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  dpra_cfg_t      cfg,
  output dpra_div_t      div
);

  dpra_div_t div_nxt;

  // Integer count is stored minus one; fraction is num over modulus
  assign div_nxt.int_div  = {1'b0, cfg.int_m1} + 18'h0_0001;
  assign div_nxt.frac_ok  = cfg.num < cfg.modulus;
  assign div_nxt.mod_zero = cfg.modulus == 23'h00_0000;

  // Registered result for the loop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div <= '0;
    else
      div <= div_nxt;
  end

endmodule // dpra_div_calc

// >>> hw/dpra_regs.sv
// Summary of operation
// - Two-bit rank field [2:1] gives reference A switchover rank, 00 highest; reset 00.
// - Bit 0 lets the first digital loop use reference A; resets to one.
// - Loop bandwidth is 16 bits, low then high byte, 0.1 Hz steps, reset 500.
// - Filter select bit: clear is normal 70 degree margin, set is high margin.
// - Integer count minus one over three registers, top bit in bit 0; reset 1995.
// - Numerator is 23 bits over three registers, bit 7 of top reserved; reset 4.
// - Modulus is 23 bits over three registers, bit 7 of top reserved; reset 5.
//
// The APB slave port was decided locally.
module dpra_regs
  import dpra_pkg::*;
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [DPRA_AW-1:0]   paddr,
  input  wire logic [DPRA_DW-1:0]   pwdata,
  input  wire logic [3:0]           pstrb,
  output logic      [DPRA_DW-1:0]   prdata,
  output logic                      pready,
  output logic                      pslverr,
  output dpra_cfg_t                 cfg,
  output dpra_div_t                 div
);

  // Decode of a byte address into a bank slot
  typedef struct packed {
    logic       hit;
    logic       status;
    logic [3:0] slot;
  } dpra_dec_t;

  function automatic dpra_dec_t dpra_decode(input logic [DPRA_AW-1:0] addr);
    dpra_dec_t   d;
    logic [11:0] idx;
    d      = '0;
    idx    = addr[13:2];
    if (addr[1:0] == 2'b00 && addr[DPRA_AW-1:14] == '0)
    begin
      if (idx >= DPRA_IDX_PRIO_EN && idx <= DPRA_IDX_MOD_HIGH)
      begin
        d.hit  = 1'b1;
        d.slot = 4'(idx - DPRA_IDX_PRIO_EN);
      end
      else if (idx == DPRA_IDX_STATUS)
      begin
        d.hit    = 1'b1;
        d.status = 1'b1;
      end
    end
    return d;
  endfunction

  // Bank slots, counted from the first register index
  localparam logic [3:0] SLOT_PRIO_EN  = 4'(DPRA_IDX_PRIO_EN  - DPRA_IDX_PRIO_EN);
  localparam logic [3:0] SLOT_BW_LOW   = 4'(DPRA_IDX_BW_LOW   - DPRA_IDX_PRIO_EN);
  localparam logic [3:0] SLOT_BW_HIGH  = 4'(DPRA_IDX_BW_HIGH  - DPRA_IDX_PRIO_EN);
  localparam logic [3:0] SLOT_LF_SEL   = 4'(DPRA_IDX_LF_SEL   - DPRA_IDX_PRIO_EN);
  localparam logic [3:0] SLOT_INT_LOW  = 4'(DPRA_IDX_INT_LOW  - DPRA_IDX_PRIO_EN);
  localparam logic [3:0] SLOT_INT_MID  = 4'(DPRA_IDX_INT_MID  - DPRA_IDX_PRIO_EN);
  localparam logic [3:0] SLOT_INT_TOP  = 4'(DPRA_IDX_INT_TOP  - DPRA_IDX_PRIO_EN);
  localparam logic [3:0] SLOT_NUM_LOW  = 4'(DPRA_IDX_NUM_LOW  - DPRA_IDX_PRIO_EN);
  localparam logic [3:0] SLOT_NUM_MID  = 4'(DPRA_IDX_NUM_MID  - DPRA_IDX_PRIO_EN);
  localparam logic [3:0] SLOT_NUM_HIGH = 4'(DPRA_IDX_NUM_HIGH - DPRA_IDX_PRIO_EN);
  localparam logic [3:0] SLOT_MOD_LOW  = 4'(DPRA_IDX_MOD_LOW  - DPRA_IDX_PRIO_EN);
  localparam logic [3:0] SLOT_MOD_MID  = 4'(DPRA_IDX_MOD_MID  - DPRA_IDX_PRIO_EN);
  localparam logic [3:0] SLOT_MOD_HIGH = 4'(DPRA_IDX_MOD_HIGH - DPRA_IDX_PRIO_EN);

  // Read map; slots past the last register read as zero instead of unknown
  function automatic logic [7:0] dpra_rd_sel(input logic [3:0] slot, input logic [DPRA_NREG-1:0][7:0] bytes);
    logic [7:0] b;
    b = 8'h00;
    if (slot < 4'(DPRA_NREG))
    begin
      b = bytes[slot];
    end
    return b;
  endfunction

  // Status word: integer division in the low bits, fraction flags above
  function automatic logic [DPRA_DW-1:0] dpra_status_word(input dpra_div_t dv);
    logic [DPRA_DW-1:0] w;
    w                           = '0;
    w[$bits(dv.int_div)-1:0]    = dv.int_div;
    w[DPRA_ST_FRACOK]           = dv.frac_ok;
    w[DPRA_ST_MODZ]             = dv.mod_zero;
    return w;
  endfunction

  // Handshake state
  dpra_apb_st_t              st_r;
  dpra_apb_st_t              st_nxt;
  logic      [DPRA_DW-1:0]   prdata_nxt;
  logic                      pslverr_nxt;

  // Bank storage and its byte view
  logic      [7:0]           bank [DPRA_NREG];
  logic      [DPRA_NREG-1:0] bank_we;
  wire logic [DPRA_NREG-1:0][7:0] bank_pk;

  // Bus decode
  dpra_dec_t                 dec;
  wire logic                 access_phase;
  wire logic                 commit;
  wire logic                 wr_commit;
  wire logic [7:0]           wr_byte;
  wire logic [7:0]           rd_byte;
  wire logic [DPRA_DW-1:0]   rd_word;
  wire logic [DPRA_DW-1:0]   status_word;

  assign dec          = dpra_decode(paddr);
  assign access_phase = psel && penable;
  assign commit       = access_phase && pready;
  assign wr_commit    = commit && pwrite && dec.hit && !dec.status && pstrb[0];
  assign wr_byte      = pwdata[7:0];

  // Write strobe per bank slot
  genvar g;
  generate
    for (g = 0; g < DPRA_NREG; g++)
    begin : g_bank
      assign bank_we[g] = wr_commit && (dec.slot == 4'(g));
      assign bank_pk[g] = bank[g];

      dpra_byte_reg #(
        .RST_VAL (DPRA_RST[g]),
        .WR_MASK (DPRA_MASK[g])
      ) u_byte (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (bank_we[g]),
        .wdata   (wr_byte),
        .q       (bank[g])
      );
    end
  endgenerate

  // Named views of the bank bytes
  wire logic [DPRA_BW-1:0]   prio_en_r;
  wire logic [DPRA_BW-1:0]   bw_low_r;
  wire logic [DPRA_BW-1:0]   bw_high_r;
  wire logic [DPRA_BW-1:0]   lf_sel_r;
  wire logic [DPRA_BW-1:0]   int_low_r;
  wire logic [DPRA_BW-1:0]   int_mid_r;
  wire logic [DPRA_BW-1:0]   int_top_r;
  wire logic [DPRA_BW-1:0]   num_low_r;
  wire logic [DPRA_BW-1:0]   num_mid_r;
  wire logic [DPRA_BW-1:0]   num_high_r;
  wire logic [DPRA_BW-1:0]   mod_low_r;
  wire logic [DPRA_BW-1:0]   mod_mid_r;
  wire logic [DPRA_BW-1:0]   mod_high_r;

  // Each view is one bank slot
  assign prio_en_r  = bank[SLOT_PRIO_EN];
  assign bw_low_r   = bank[SLOT_BW_LOW];
  assign bw_high_r  = bank[SLOT_BW_HIGH];
  assign lf_sel_r   = bank[SLOT_LF_SEL];
  assign int_low_r  = bank[SLOT_INT_LOW];
  assign int_mid_r  = bank[SLOT_INT_MID];
  assign int_top_r  = bank[SLOT_INT_TOP];
  assign num_low_r  = bank[SLOT_NUM_LOW];
  assign num_mid_r  = bank[SLOT_NUM_MID];
  assign num_high_r = bank[SLOT_NUM_HIGH];
  assign mod_low_r  = bank[SLOT_MOD_LOW];
  assign mod_mid_r  = bank[SLOT_MOD_MID];
  assign mod_high_r = bank[SLOT_MOD_HIGH];

  // Read selection: bank byte in the low lane with upper bits zero, or the status word
  assign rd_byte     = dpra_rd_sel(dec.slot, bank_pk);
  assign status_word = dpra_status_word(div);
  assign rd_word     = dec.status ? status_word : {24'h00_0000, rd_byte};

  // Priority and enable
  assign cfg.enable  = prio_en_r[DPRA_EN_BIT];
  assign cfg.rank    = prio_en_r[DPRA_RANK_LSB +: 2];

  // Loop bandwidth, low byte then high byte
  assign cfg.loop_bw = {bw_high_r, bw_low_r};

  // Base loop filter margin
  assign cfg.margin  = lf_sel_r[DPRA_LF_BIT] ? DPRA_MARGIN_HIGH
                                             : DPRA_MARGIN_NORMAL;

  // Integer count minus one, top bit from the third byte
  assign cfg.int_m1  = {int_top_r[DPRA_INTTOP_B], int_mid_r, int_low_r};

  // Fractional numerator and modulus, seven top bits each
  assign cfg.num     = {num_high_r[6:0], num_mid_r, num_low_r};
  assign cfg.modulus = {mod_high_r[6:0], mod_mid_r, mod_low_r};

  // Effective division for the loop
  dpra_div_calc u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .cfg     (cfg),
    .div     (div)
  );

  // Next-state: one wait state, then the answer cycle
  always_comb
  begin
    st_nxt      = st_r;
    prdata_nxt  = prdata;
    pslverr_nxt = pslverr;
    case (st_r)
      DPRA_IDLE:
      begin
        if (access_phase)
        begin
          st_nxt      = DPRA_ANSWER;
          pslverr_nxt = !dec.hit;
          prdata_nxt  = (!pwrite && dec.hit) ? rd_word : '0;
        end
      end
      DPRA_ANSWER:
      begin
        st_nxt      = DPRA_IDLE;
        pslverr_nxt = 1'b0;
        prdata_nxt  = '0;
      end
      default:
      begin
        st_nxt      = DPRA_IDLE;
        pslverr_nxt = 1'b0;
        prdata_nxt  = '0;
      end
    endcase
  end

  // Handshake and answer registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r    <= DPRA_IDLE;
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      pready  <= (st_nxt == DPRA_ANSWER);
      prdata  <= prdata_nxt;
      pslverr <= pslverr_nxt;
    end
  end

endmodule // dpra_regs

// >>> verification/dpra_regs_monitor.sv
module dpra_regs_monitor
  import dpra_pkg::*;
(
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [DPRA_AW-1:0]   paddr,
  input wire logic [DPRA_DW-1:0]   pwdata,
  input wire logic [3:0]           pstrb,
  input wire logic [DPRA_DW-1:0]   prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire dpra_cfg_t            cfg,
  input wire dpra_div_t            div
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Decode of the bank and status places
  logic hit;
  logic wr_ok;
  assign hit = paddr[15:14] == 2'b00 && paddr[1:0] == 2'b00 && paddr[13:2] inside {[12'h0440:12'h044C], 12'h0460};
  assign wr_ok = psel && penable && pready && pwrite && pstrb[0];

  // Handshake timing
  rdy_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no ready");
  one_pulse_a: assert property (pready |=> !pready) else $error("ready too long");
  err_map_a: assert property (pready |-> pslverr == !hit) else $error("bad error flag");
  rd_idle_a: assert property (!pready |-> prdata == '0) else $error("stale read data");

  // Register contents
  rst_val_a: assert property ($rose(presetn) |-> cfg.enable && cfg.loop_bw == 16'h01F4 &&
    cfg.int_m1 == 17'h0_07CB) else $error("bad reset value");
  cfg_hold_a: assert property (!wr_ok |=> $stable(cfg)) else $error("config moved");
  prio_take_a: assert property (wr_ok && paddr == 16'h1100 |=>
    cfg.enable == $past(pwdata[0]) && cfg.rank == $past(pwdata[2:1])) else $error("priority lost");
  margin_take_a: assert property (wr_ok && paddr == 16'h110C |=>
    cfg.margin == $past(pwdata[1])) else $error("margin lost");

  // Division follows config one cycle later
  div_int_a: assert property ($past(presetn) |-> div.int_div == $past(cfg.int_m1) + 18'd1)
    else $error("bad integer division");
  div_frac_a: assert property ($past(presetn) |-> div.frac_ok == ($past(cfg.num) < $past(cfg.modulus))
    && div.mod_zero == ($past(cfg.modulus) == 0)) else $error("bad fraction flags");

  cover property (wr_ok);
  cover property (pslverr);
  cover property (div.mod_zero);
endmodule // dpra_regs_monitor

bind dpra_regs dpra_regs_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cfg(cfg), .div(div));

// >>> verification/tb.sv
module tb
  import dpra_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, ge;
  logic [15:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, got;
  logic [19:0] ed;
  logic [3:0]  pstrb = '0;
  dpra_cfg_t   cfg;
  dpra_div_t   div;
  int          n_errors = 0, n_compared = 0, i;
  logic [7:0]  m [13];
  localparam logic [7:0] RSTV [13] = '{8'h01, 8'hF4, 8'h01, 8'h00, 8'hCB, 8'h07, 8'h00,
    8'h04, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00};
  localparam logic [7:0] MSK [13] = '{8'h07, 8'hFF, 8'hFF, 8'h02, 8'hFF, 8'hFF, 8'h01,
    8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF, 8'h7F};

  dpra_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cfg(cfg), .div(div));

  // 125 MHz clock
  initial forever #4 pclk = ~pclk;

  // Expected settings from the byte model
  function automatic dpra_cfg_t ecfg();
    ecfg = {m[0][0], m[0][2:1], m[2], m[1], dpra_margin_t'(m[3][1]), m[6][0], m[5], m[4],
      m[9][6:0], m[8], m[7], m[12][6:0], m[11], m[10]};
  endfunction

  // Expected division from settings
  function automatic logic [19:0] fdiv(dpra_cfg_t c);
    fdiv = {{1'b0, c.int_m1} + 18'd1, c.num < c.modulus, c.modulus == 0};
  endfunction

  task automatic chk(input string n, input logic [127:0] g, e);
    n_compared++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // One APB transfer at bank index i
  task automatic xfer(input logic w, input int i, input logic [7:0] d, input logic [3:0] s);
    int k;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= 16'((12'h440 + i) * 4);
    pwdata <= {24'($urandom), d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1);
    chk("wait", k, 2);
    got = prdata;
    ge = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  task automatic wr(input int i, input logic [7:0] d);
    xfer(1, i, d, 4'h1);
    m[i] = d & MSK[i];
  endtask

  // Outputs have settled by the second edge after a write
  task automatic cmp();
    repeat (2) @(posedge pclk);
    #1;
    chk("cfg", cfg, ecfg());
    chk("div", div, fdiv(ecfg()));
  endtask

  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    #200000;
    n_errors++;
    conclude();
  end

  // Test sequence
  initial
  begin
    void'($urandom(73));
    repeat (3) @(posedge pclk);
    presetn <= 1;
    m = RSTV;
    for (int r = 0; r < 13; r++)
    begin
      xfer(0, r, 0, 4'h0);
      chk("reset", got, RSTV[r]);
    end
    cmp();
    $display("reset values done");
    for (int r = 0; r < 4; r++)
    begin
      wr(0, 8'(r * 2));
      cmp();
    end
    $display("ranks done");
    repeat (60)
    begin
      i = $urandom_range(12);
      wr(i, 8'($urandom));
      xfer(0, i, 0, 4'h0);
      chk("readback", got, m[i]);
      cmp();
    end
    $display("random done");
    xfer(1, 13, 8'hFF, 4'h1);
    chk("err", ge, 1);
    xfer(0, 13, 0, 4'h0);
    chk("err", {ge, got}, {1'b1, 32'h0});
    xfer(1, 1, 8'h5A, 4'h0);
    xfer(1, 32, 8'hFF, 4'h1);
    cmp();
    xfer(0, 32, 0, 4'h0);
    ed = fdiv(ecfg());
    chk("status", got, {6'd0, ed[0], ed[1], 6'd0, ed[19:2]});
    $display("refusals done");
    wr(10, 0);
    wr(11, 0);
    wr(12, 0);
    cmp();
    $display("zero modulus done");
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    m = RSTV;
    cmp();
    xfer(0, 0, 0, 4'h0);
    chk("reset again", got, RSTV[0]);
    $display("mid-run reset done");
    conclude();
  end
endmodule // tb
